//--- adcc_defs.svh
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_CLK_NS 10
`define ADCC_ACQ_TIME_NS 1400
`define ADCC_PWR_TIME_NS 1000
`define ADCC_ACQ_CYC ((`ADCC_ACQ_TIME_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_PWR_CYC ((`ADCC_PWR_TIME_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_CONV_TIME_NS 2000
`define ADCC_SAMPLE_TIME_NS (`ADCC_ACQ_TIME_NS + `ADCC_CONV_TIME_NS)
`define ADCC_TEMP_TIME_NS 5000
`define ADCC_REFWAKE_TIME_NS 65000
`define ADCC_OSC_KHZ 4400
`define ADCC_OSC_TOL_PCT 10
`define ADCC_FIFO_DEPTH 16
`define ADCC_CONV_START_PIN_N_CHAN 4'hF
`define ADCC_REFN_CHAN 4'hE
`define ADCC_MODE_DEFAULT 2'h2
`define ADCC_SEL_UNI 2'h2
`define ADCC_SEL_BIP 2'h3
`endif

//--- adcc_pkg.sv
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_MODE_PIN_SCAN = 2'h0,
    ADCC_MODE_PIN_EACH = 2'h1,
    ADCC_MODE_SER_INT = 2'h2,
    ADCC_MODE_EXT_CLK = 2'h3
  } adcc_mode_t;
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'h1,
    ADCC_PWR = 3'h2,
    ADCC_ACQ = 3'h4
  } adcc_acq_t;
  typedef struct packed {
    logic [3:0] chan;
    logic signed [12:0] diff;
  } adcc_sample_t;
  typedef struct packed {
    logic [7:0] uni;
    logic [7:0] bip;
    adcc_mode_t mode;
  } adcc_cfg_t;
endpackage

//--- adcc_ctrl.sv
// Operation
// - differential pairs are even/odd channels, even positive, odd negative
// - single-ended channels convert against ground with unipolar coding
// - shared start pin acts as start input or analog input, never both
// - pin configured as negative reference is never an analog channel
// - a one in either pair register makes that pair differential
// - negative difference in unipolar differential gives all-zero code
// - unipolar codes straight binary, bipolar codes two's complement
// - buffer holds sixteen results plus one temperature slot
// - full buffer overwrites oldest result with each new one
// - each result is two bytes, four zero bits ahead of the MSB
// - after chip select falls, oldest unread byte goes out MSB first
// - empty buffer reads out as zeros
// - pending temperature result is read out before voltage results
// - new temperature result replaces an unread older one
// - temperature is two's complement, one eighth degree per LSB
// - internal oscillator runs only in clock modes 00, 01 and 10
// - internally timed acquisition lasts at least 1.4us incl. 1us power-up
// - modes 00/10 scan time is sample time x averages x results plus extras
// - pair-select 10 routes next byte to unipolar, 11 to bipolar register
// - pair marked both unipolar and bipolar acts unipolar
// - setup bits five and four pick the clock mode, default 10
`timescale 1ns/1ns
`include "adcc_defs.svh"
module adcc_ctrl
  import adcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic conv_start_pin_n,
  input wire logic conv_start_pin_n_pin_is_start,
  input wire logic refn_pin_is_ref,
  input wire logic sample_done,
  input wire adcc_sample_t sample,
  input wire logic temp_done,
  input wire logic [11:0] temp_code,
  input wire logic [5:0] avg_count,
  input wire logic [4:0] result_count,
  input wire logic temp_requested,
  input wire logic ref_was_off,
  output logic [15:0] analog_input_en,
  output logic [7:0] pair_diff,
  output logic [7:0] pair_bipolar,
  output adcc_mode_t clock_mode,
  output logic osc_enable,
  output logic conv_request,
  output logic powerup_active,
  output logic acq_active,
  output logic acq_done,
  output logic [31:0] scan_time_ns,
  output logic [4:0] fifo_count,
  output logic temp_pending
);
  // ---------------- link side (serial clock) ----------------
  logic link_rst_n;
  assign link_rst_n = resetn & ~cs_n;
  logic [2:0] rx_cnt_q;
  logic [6:0] rx_sh_q;
  logic [1:0] route_q;
  adcc_cfg_t lcfg_q;
  logic cfg_tgl_q;
  logic conv_tgl_q;
  logic [7:0] rx_byte;
  assign rx_byte = {rx_sh_q, din};
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 7'h00;
      route_q <= 2'h0;
    end else begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
      rx_sh_q <= rx_byte[6:0];
      if (rx_cnt_q == 3'h7)
        route_q <= (!route_q[1] && rx_byte[7:6] == 2'h1) ? rx_byte[1:0] : 2'h0;
    end
  end
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      lcfg_q <= '{uni: 8'h00, bip: 8'h00, mode: adcc_mode_t'(`ADCC_MODE_DEFAULT)};
      cfg_tgl_q <= 1'b0;
      conv_tgl_q <= 1'b0;
    end else if (!cs_n && rx_cnt_q == 3'h7) begin
      if (route_q == `ADCC_SEL_UNI) begin
        lcfg_q.uni <= rx_byte;
        cfg_tgl_q <= ~cfg_tgl_q;
      end else if (route_q == `ADCC_SEL_BIP) begin
        lcfg_q.bip <= rx_byte;
        cfg_tgl_q <= ~cfg_tgl_q;
      end else if (rx_byte[7:6] == 2'h1) begin
        lcfg_q.mode <= adcc_mode_t'(rx_byte[5:4]);
        cfg_tgl_q <= ~cfg_tgl_q;
      end else if (rx_byte[7]) begin
        conv_tgl_q <= ~conv_tgl_q;
      end
    end
  end

  // readout: falling edges walk the bits of the presented byte
  logic [2:0] tx_cnt_q;
  logic pop_tgl_q;
  logic [7:0] tx_byte_q;
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n)
      tx_cnt_q <= 3'h0;
    else
      tx_cnt_q <= tx_cnt_q + 3'h1;
  end
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn)
      pop_tgl_q <= 1'b0;
    else if (!cs_n && tx_cnt_q == 3'h7)
      pop_tgl_q <= ~pop_tgl_q;
  end
  assign dout = tx_byte_q[3'h7 - tx_cnt_q];
  assign dout_oe = ~cs_n;

  // ---------------- system side ----------------
  logic [1:0] cfg_sync_q;
  logic [1:0] conv_sync_q;
  logic [1:0] pop_sync_q;
  logic [1:0] pin_sync_q;
  logic cfg_seen_q;
  logic conv_seen_q;
  logic pop_seen_q;
  logic pin_last_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_sync_q <= 2'h0;
      conv_sync_q <= 2'h0;
      pop_sync_q <= 2'h0;
      pin_sync_q <= 2'h3;
      cfg_seen_q <= 1'b0;
      conv_seen_q <= 1'b0;
      pop_seen_q <= 1'b0;
      pin_last_q <= 1'b1;
    end else begin
      cfg_sync_q <= {cfg_sync_q[0], cfg_tgl_q};
      conv_sync_q <= {conv_sync_q[0], conv_tgl_q};
      pop_sync_q <= {pop_sync_q[0], pop_tgl_q};
      pin_sync_q <= {pin_sync_q[0], conv_start_pin_n};
      cfg_seen_q <= cfg_sync_q[1];
      conv_seen_q <= conv_sync_q[1];
      pop_seen_q <= pop_sync_q[1];
      pin_last_q <= pin_sync_q[1];
    end
  end
  logic cfg_ev;
  logic conv_ev;
  logic pop_ev;
  logic pin_fall;
  assign cfg_ev = cfg_sync_q[1] ^ cfg_seen_q;
  assign conv_ev = conv_sync_q[1] ^ conv_seen_q;
  assign pop_ev = pop_sync_q[1] ^ pop_seen_q;
  assign pin_fall = pin_last_q & ~pin_sync_q[1];

  // link config is stable between toggles, so it is captured on the event
  adcc_cfg_t cfg_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      cfg_q <= '{uni: 8'h00, bip: 8'h00, mode: adcc_mode_t'(`ADCC_MODE_DEFAULT)};
    else if (cfg_ev)
      cfg_q <= lcfg_q;
  end
  assign clock_mode = cfg_q.mode;
  assign pair_diff = cfg_q.uni | cfg_q.bip;
  assign pair_bipolar = cfg_q.bip & ~cfg_q.uni;
  assign osc_enable = (cfg_q.mode != ADCC_MODE_EXT_CLK);

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_en
      if (gi == `ADCC_CONV_START_PIN_N_CHAN)
        assign analog_input_en[gi] = ~conv_start_pin_n_pin_is_start;
      else if (gi == `ADCC_REFN_CHAN)
        assign analog_input_en[gi] = ~refn_pin_is_ref;
      else
        assign analog_input_en[gi] = 1'b1;
    end
  endgenerate

  // start requests: pin in modes 00/01, only when it is the start input; serial in modes 10/11
  logic pin_mode;
  assign pin_mode = (cfg_q.mode == ADCC_MODE_PIN_SCAN) || (cfg_q.mode == ADCC_MODE_PIN_EACH);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      conv_request <= 1'b0;
    else
      conv_request <= pin_mode ? (pin_fall & conv_start_pin_n_pin_is_start) : conv_ev;
  end

  // internally timed acquisition with leading power-up interval
  adcc_acq_t acq_q;
  logic [7:0] acq_cnt_q;
  logic int_start;
  assign int_start = conv_request & (cfg_q.mode != ADCC_MODE_EXT_CLK);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acq_q <= ADCC_IDLE;
      acq_cnt_q <= 8'h00;
      acq_done <= 1'b0;
    end else begin
      acq_done <= 1'b0;
      case (acq_q)
        ADCC_IDLE: begin
          acq_cnt_q <= 8'h00;
          if (int_start)
            acq_q <= ADCC_PWR;
        end
        ADCC_PWR: begin
          acq_cnt_q <= acq_cnt_q + 8'h01;
          if (acq_cnt_q == 8'(`ADCC_PWR_CYC - 1))
            acq_q <= ADCC_ACQ;
        end
        ADCC_ACQ: begin
          acq_cnt_q <= acq_cnt_q + 8'h01;
          if (acq_cnt_q == 8'(`ADCC_ACQ_CYC - 1)) begin
            acq_q <= ADCC_IDLE;
            acq_done <= 1'b1;
          end
        end
        default: acq_q <= ADCC_IDLE;
      endcase
    end
  end
  assign powerup_active = (acq_q == ADCC_PWR);
  assign acq_active = (acq_q != ADCC_IDLE);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      scan_time_ns <= 32'h0;
    else if (cfg_q.mode == ADCC_MODE_PIN_SCAN || cfg_q.mode == ADCC_MODE_SER_INT)
      scan_time_ns <= 32'(`ADCC_SAMPLE_TIME_NS) * 32'(avg_count) * 32'(result_count)
        + (temp_requested ? 32'(`ADCC_TEMP_TIME_NS) : 32'h0)
        + (ref_was_off ? 32'(`ADCC_REFWAKE_TIME_NS) : 32'h0);
    else
      scan_time_ns <= 32'h0;
  end

  // result coding
  function automatic logic [11:0] code_of(input adcc_sample_t s, input logic [7:0] dif, input logic [7:0] bip);
    logic [2:0] p;
    logic signed [12:0] half;
    p = s.chan[3:1];
    half = s.diff >>> 1;
    if (dif[p] && bip[p])
      code_of = half[11:0];
    else if (s.diff < 0)
      code_of = 12'h000;
    else
      code_of = s.diff[11:0];
  endfunction

  logic ch_ok;
  logic push;
  assign ch_ok = analog_input_en[sample.chan] &
    (~pair_diff[sample.chan[3:1]] | analog_input_en[{sample.chan[3:1], 1'b1}]);
  assign push = sample_done & ch_ok;

  // result FIFO plus temperature slot
  logic [11:0] mem_q [`ADCC_FIFO_DEPTH];
  logic [3:0] wr_q;
  logic [3:0] rd_q;
  logic [4:0] cnt_q;
  logic [11:0] temp_q;
  logic temp_v_q;
  logic lo_q;
  logic full;
  logic head_temp;
  logic drop;
  logic drop_fifo;
  logic adv_rd;
  assign full = (cnt_q == 5'(`ADCC_FIFO_DEPTH));
  assign head_temp = temp_v_q;
  assign drop = pop_ev & lo_q & (temp_v_q | (cnt_q != 5'h0));
  assign drop_fifo = drop & ~head_temp;
  assign adv_rd = drop_fifo | (push & full);
  always_ff @(posedge sys_clk) begin
    if (push)
      mem_q[wr_q] <= code_of(sample, pair_diff, pair_bipolar);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (push)
        wr_q <= wr_q + 4'h1;
      if (adv_rd)
        rd_q <= rd_q + 4'h1;
      if (push && !full && !drop_fifo)
        cnt_q <= cnt_q + 5'h01;
      else if (!push && drop_fifo)
        cnt_q <= cnt_q - 5'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      temp_q <= 12'h000;
      temp_v_q <= 1'b0;
    end else if (temp_done) begin
      temp_q <= temp_code;
      temp_v_q <= 1'b1;
    end else if (drop && head_temp) begin
      temp_v_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      lo_q <= 1'b0;
    else if (pop_ev && (temp_v_q || cnt_q != 5'h0))
      lo_q <= ~lo_q;
  end
  logic [11:0] head;
  assign head = head_temp ? temp_q : ((cnt_q != 5'h0) ? mem_q[rd_q] : 12'h000);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      tx_byte_q <= 8'h00;
    else
      tx_byte_q <= lo_q ? head[7:0] : {4'h0, head[11:8]};
  end
  assign fifo_count = cnt_q;
  assign temp_pending = temp_v_q;
endmodule

//--- adcc_ctrl_sva.sv
`timescale 1ns/1ns
`include "adcc_defs.svh"
module adcc_ctrl_chk
  import adcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic conv_start_pin_n_pin_is_start,
  input wire logic refn_pin_is_ref,
  input wire logic [5:0] avg_count,
  input wire logic [4:0] result_count,
  input wire logic temp_requested,
  input wire logic ref_was_off,
  input wire logic [15:0] analog_input_en,
  input wire logic [7:0] pair_diff,
  input wire logic [7:0] pair_bipolar,
  input wire adcc_mode_t clock_mode,
  input wire logic osc_enable,
  input wire logic powerup_active,
  input wire logic acq_active,
  input wire logic acq_done,
  input wire logic [31:0] scan_time_ns,
  input wire logic [4:0] fifo_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [9:0] busy_q;
  // cycles spent powering up plus acquiring
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 10'h000;
    end else begin
      busy_q <= (powerup_active || acq_active) ? busy_q + 10'h001 : 10'h000;
    end
  end
  a_osc_by_mode: assert property (osc_enable == (clock_mode != ADCC_MODE_EXT_CLK))
    else $error("osc enable wrong");
  a_bip_is_diff: assert property ((pair_bipolar & ~pair_diff) == 8'h00)
    else $error("bipolar pair not differential");
  a_start_excl: assert property (conv_start_pin_n_pin_is_start |-> !analog_input_en[15])
    else $error("start pin used as input");
  a_refn_excl: assert property (refn_pin_is_ref |-> !analog_input_en[14])
    else $error("ref pin used as input");
  a_fifo_depth: assert property (fifo_count <= 5'h10)
    else $error("fifo count above depth");
  a_acq_length: assert property (acq_done |-> busy_q == 10'(`ADCC_ACQ_CYC))
    else $error("acquisition length wrong");
  a_pwr_first: assert property ($fell(powerup_active) |-> acq_active && busy_q == 10'(`ADCC_PWR_CYC))
    else $error("power-up length wrong");
  a_scan_sum: assert property (clock_mode inside {ADCC_MODE_PIN_SCAN, ADCC_MODE_SER_INT} && $past(resetn)
    && $stable(clock_mode) && $stable({avg_count, result_count, temp_requested, ref_was_off})
    |-> scan_time_ns == 32'(`ADCC_SAMPLE_TIME_NS * avg_count * result_count)
    + (temp_requested ? `ADCC_TEMP_TIME_NS : 0) + (ref_was_off ? `ADCC_REFWAKE_TIME_NS : 0))
    else $error("scan time wrong");
  a_mode_default: assert property ($rose(resetn) |-> clock_mode == ADCC_MODE_SER_INT)
    else $error("clock mode not default");
endmodule
bind adcc_ctrl adcc_ctrl_chk adcc_ctrl_chk_i (.sys_clk, .resetn, .conv_start_pin_n_pin_is_start, .refn_pin_is_ref,
  .avg_count, .result_count, .temp_requested, .ref_was_off, .analog_input_en, .pair_diff, .pair_bipolar,
  .clock_mode, .osc_enable, .powerup_active, .acq_active, .acq_done, .scan_time_ns, .fifo_count);

//--- adcc_host.sv
`timescale 1ns/1ns
module adcc_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic lk;
  initial begin
    lk = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    #7;
    forever #16 lk = ~lk;
  end
  // half serial period of two link cycles keeps sclk under 10MHz
  task automatic half();
    repeat (2) @(posedge lk);
  endtask
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge lk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = tx[15-i];
      half();
      sclk = 1'b1;
      rx = {rx[14:0], dout_oe ? dout : 1'bx};
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    din = ~din;
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ns
`include "adcc_defs.svh"
module tb
  import adcc_pkg::*;
;
  logic sys_clk, resetn, sclk, cs_n, din, dout, dout_oe, conv_start_pin_n, conv_start_pin_n_pin_is_start, refn_pin_is_ref;
  logic sample_done, temp_done, temp_requested, ref_was_off, osc_enable, conv_request, powerup_active;
  logic acq_active, acq_done, temp_pending;
  adcc_sample_t sample;
  adcc_mode_t clock_mode;
  logic [11:0] temp_code;
  logic [5:0] avg_count;
  logic [4:0] result_count, fifo_count;
  logic [15:0] analog_input_en;
  logic [7:0] pair_diff, pair_bipolar;
  logic [31:0] scan_time_ns;
  int errors, tests_run, w;
  adcc_ctrl adcc_ctrl_i (.sys_clk, .resetn, .sclk, .cs_n, .din, .dout, .dout_oe, .conv_start_pin_n,
    .conv_start_pin_n_pin_is_start, .refn_pin_is_ref, .sample_done, .sample, .temp_done, .temp_code, .avg_count,
    .result_count, .temp_requested, .ref_was_off, .analog_input_en, .pair_diff, .pair_bipolar, .clock_mode,
    .osc_enable, .conv_request, .powerup_active, .acq_active, .acq_done, .scan_time_ns, .fifo_count,
    .temp_pending);
  adcc_host adcc_host_i (.sclk, .cs_n, .din, .dout, .dout_oe);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic push(input logic [3:0] ch, input logic signed [12:0] d);
    cyc(1);
    sample = '{chan: ch, diff: d};
    sample_done = 1'b1;
    cyc(1);
    sample_done = 1'b0;
  endtask
  task automatic tmp(input logic [11:0] c);
    cyc(1);
    temp_code = c;
    temp_done = 1'b1;
    cyc(1);
    temp_done = 1'b0;
  endtask
  task automatic wr(input logic [15:0] b, input int n);
    logic [15:0] r;
    adcc_host_i.xfer(b, n, r);
    cyc(8);
  endtask
  task automatic rd(input logic [15:0] exp);
    logic [15:0] r;
    adcc_host_i.xfer(16'h0000, 16, r);
    cyc(8);
    chk("readout", 32'(exp), 32'(r));
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    {resetn, sample_done, temp_done, conv_start_pin_n_pin_is_start, refn_pin_is_ref, ref_was_off} = 6'h00;
    conv_start_pin_n = 1'b1;
    temp_requested = 1'b1;
    sample = '0;
    temp_code = 12'h000;
    avg_count = 6'h04;
    result_count = 5'h03;
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    cyc(3);
    chk("mode", 32'(ADCC_MODE_SER_INT), 32'(clock_mode));
    rd(16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr({2'b01, 2'(m), 12'h000}, 8);
      chk("mode", 32'(m), 32'(clock_mode));
      chk("osc", 32'(m != 3), 32'(osc_enable));
    end
    wr(16'h6205, 16);
    wr(16'h630F, 16);
    chk("pair_diff", 32'h0F, 32'(pair_diff));
    chk("pair_bipolar", 32'h0A, 32'(pair_bipolar));
    $display("test config done");
    {conv_start_pin_n_pin_is_start, refn_pin_is_ref} = 2'b11;
    push(4'hF, 13'sd5);
    push(4'hE, 13'sd5);
    cyc(8);
    chk("shared_en", 32'h0, 32'(analog_input_en[15:14]));
    chk("fifo", 32'h0, 32'(fifo_count));
    {conv_start_pin_n_pin_is_start, refn_pin_is_ref} = 2'b00;
    cyc(1);
    chk("shared_en", 32'h3, 32'(analog_input_en[15:14]));
    $display("test pins done");
    for (int k = 0; k < 18; k++) push(4'h8, 13'(12'hA50 + k));
    tmp(12'hFF8);
    tmp(12'h0C8);
    cyc(8);
    chk("fifo", 32'd16, 32'(fifo_count));
    rd(16'h00C8);
    for (int k = 2; k < 18; k++) rd(16'(12'hA50 + k));
    chk("fifo", 32'h0, 32'(fifo_count));
    chk("temp_pending", 32'h0, 32'(temp_pending));
    $display("test fifo done");
    push(4'h2, -13'sd40);
    push(4'h0, -13'sd40);
    push(4'h8, -13'sd40);
    push(4'h2, 13'sd300);
    push(4'h0, 13'sd300);
    rd(16'h0FEC);
    rd(16'h0000);
    rd(16'h0000);
    rd(16'h0096);
    rd(16'h012C);
    $display("test coding done");
    wr(16'h8000, 8);
    w = 0;
    while (acq_done !== 1'b1 && w < 600) begin
      cyc(1);
      w++;
    end
    chk("acq_done", 32'h1, 32'(acq_done));
    chk("scan", `ADCC_SAMPLE_TIME_NS * 12 + `ADCC_TEMP_TIME_NS, scan_time_ns);
    ref_was_off = 1'b1;
    cyc(3);
    chk("scan", `ADCC_SAMPLE_TIME_NS * 12 + `ADCC_TEMP_TIME_NS + `ADCC_REFWAKE_TIME_NS, scan_time_ns);
    wr(16'h5000, 8);
    chk("scan", 32'h0, scan_time_ns);
    conv_start_pin_n = 1'b0;
    cyc(8);
    chk("acq_active", 32'h0, 32'(acq_active));
    conv_start_pin_n = 1'b1;
    conv_start_pin_n_pin_is_start = 1'b1;
    cyc(8);
    conv_start_pin_n = 1'b0;
    w = 0;
    while (conv_request !== 1'b1 && w < 20) begin
      cyc(1);
      w++;
    end
    chk("conv_request", 32'h1, 32'(conv_request));
    cyc(1);
    conv_start_pin_n = 1'b1;
    chk("powerup_active", 32'h1, 32'(powerup_active));
    w = 0;
    while (acq_done !== 1'b1 && w < 600) begin
      cyc(1);
      w++;
    end
    chk("acq_done", 32'h1, 32'(acq_done));
    wr(16'h7000, 8);
    wr(16'h8000, 8);
    chk("acq_active", 32'h0, 32'(acq_active));
    $display("test timing done");
    report_and_stop();
  end
endmodule
